/* lpc_pkg.sv */
// Constants for the regulator on/off and power-mode control block.
// Assumes a 250 MHz system clock; used by every design file of the block except lpc_debounce.
package lpc_pkg;
	// ****************************************
	// Enable source codes
	// ****************************************
	localparam logic [1:0] EN_FORCE_OFF = 2'h0;
	localparam logic [1:0] EN_FORCE_ON = 2'h1;
	localparam logic [1:0] EN_HW_SW = 2'h2;
	localparam logic [1:0] EN_RESERVED = 2'h3;
	localparam logic [1:0] EN_RESET_DEFAULT = EN_HW_SW;

	// ****************************************
	// Software power commands
	// ****************************************
	localparam logic [1:0] SW_NONE = 2'h0;
	localparam logic [1:0] SW_RESET = 2'h1;
	localparam logic [1:0] SW_POWER_OFF = 2'h2;
	localparam logic [1:0] SW_SHIP = 2'h3;

	// ****************************************
	// Power mode codes and charger detail
	// ****************************************
	localparam logic [1:0] PM_LOW = 2'h0;
	localparam logic [1:0] PM_NORMAL = 2'h1;
	localparam logic [1:0] PM_PIN_HIGH = 2'h2;
	localparam logic [1:0] PM_PIN_LOW = 2'h3;
	localparam logic [1:0] PM_RESET_DEFAULT = PM_NORMAL;
	localparam int PM_PIN_BIT = 1;
	localparam logic [1:0] CHG_VALID = 2'h3;

	// ****************************************
	// Output voltage code, values in mV
	// ****************************************
	localparam int VOUT_BITS = 7;
	localparam logic [VOUT_BITS-1:0] VOUT_RESET_DEFAULT = 7'h28;
	localparam int VOUT_BASE_MV = 800;
	localparam int VOUT_STEP_MV = 25;
	localparam int VOUT_MAX_MV = 3975;
	localparam int MV_BITS = 12;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ = 250;
	localparam int DBNC_US = 30;
	localparam int DBNC_CYCLES = DBNC_US * CLK_MHZ;
	localparam int SEQ_US = 10;
	localparam int SEQ_CYCLES = SEQ_US * CLK_MHZ;
endpackage

/* lpc_debounce.sv */
// Debounce filter: output follows the input after it held steady N cycles.
// Assumes the input is already synchronous to sys_clk.
`timescale 1ns/1ps
module lpc_debounce #(
	parameter int CYCLES = 16
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Level in and filtered level out
	input wire logic din,
	output logic dout
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] TOP = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic dout_q;
	logic dout_d;
	wire differs = din != dout_q;
	wire done = differs && (cnt_q == TOP);

	initial if (CYCLES < 1) $error("lpc_debounce: CYCLES must be at least 1");

	assign cnt_d = (!differs || done) ? '0 : cnt_q + CW'(1);
	assign dout_d = done ? din : dout_q;
	assign dout = dout_q;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			cnt_q <= '0;
			dout_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			dout_q <= dout_d;
		end
	end
endmodule

/* lpc_vout_decode.sv */
// Output voltage code to target millivolts and power-good thresholds.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
module lpc_vout_decode (
	// Code in
	input wire logic [lpc_pkg::VOUT_BITS-1:0] code,
	// Decoded values in mV
	output logic [lpc_pkg::MV_BITS-1:0] target_mv,
	output logic [lpc_pkg::MV_BITS-1:0] rise_mv,
	output logic [lpc_pkg::MV_BITS-1:0] fall_mv
);
	localparam int W = 20;
	wire [W-1:0] mv = W'(lpc_pkg::VOUT_BASE_MV) + W'(code) * W'(lpc_pkg::VOUT_STEP_MV);
	// 87.5% as 7/8 and 84% as 21/25, truncated
	wire [W-1:0] rise = (mv * W'(7)) >> 3;
	wire [W-1:0] fall = (mv * W'(21)) / W'(25);

	assign target_mv = mv[lpc_pkg::MV_BITS-1:0];
	assign rise_mv = rise[lpc_pkg::MV_BITS-1:0];
	assign fall_mv = fall[lpc_pkg::MV_BITS-1:0];
endmodule

/* lpc_ctrl.sv */
// Regulator on/off controller, power-mode select and power-good output.
// Function
// - Enable code 01 forces on, power-up
// - Enable code 00 forces off, power-down
// - Code 10: debounced enable pin wakes regulator
// - Code 10: valid charger input wakes regulator
// - Software reset with default 10 wakes later
// - Lockouts force regulator off
// - Software off, reset, ship force off
// - Watchdog expiry or manual reset force off
// - Enable reset value is factory strap
// - Code maps 0.8V plus 25mV steps
// - Mode codes 00/01 fix low/normal
// - Codes 10/11 follow mode pin, 11 inverted
// - Power-good follows rise/fall comparators
// - Power-good blanked during sequences
// - Active discharge after regulator disabled
// Assumes all inputs are synchronous to sys_clk; flags from other blocks are levels.
`timescale 1ns/1ps
module lpc_ctrl #(
	parameter logic [1:0] EN_DEFAULT = lpc_pkg::EN_RESET_DEFAULT,
	parameter int DBNC_CYCLES = lpc_pkg::DBNC_CYCLES,
	parameter int SEQ_CYCLES = lpc_pkg::SEQ_CYCLES
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Configuration fields, with write strobes
	input wire logic [1:0] reg_enable_sel,
	input wire logic reg_enable_sel_wr,
	input wire logic [lpc_pkg::VOUT_BITS-1:0] reg_vout_code,
	input wire logic reg_vout_code_wr,
	input wire logic [1:0] reg_power_mode_sel,
	input wire logic reg_power_mode_sel_wr,
	input wire logic [1:0] software_power_cmd,
	input wire logic software_power_cmd_wr,
	// Hardware inputs
	input wire logic enable_pin_n,
	input wire logic [1:0] charger_input_detail,
	input wire logic reg_mode_pin,
	input wire logic sys_uvlo,
	input wire logic sys_ovlo,
	input wire logic over_temp,
	input wire logic watchdog_enabled,
	input wire logic watchdog_expired_flag,
	input wire logic manual_reset_flag,
	input wire logic reset_actions_done,
	// Power-good comparators
	input wire logic vout_above_rise,
	input wire logic vout_below_fall,
	// Regulator controls
	output logic reg_on,
	output logic reg_normal_mode,
	output logic reg_discharge_en,
	output logic [lpc_pkg::VOUT_BITS-1:0] reg_vout_code_out,
	output logic [lpc_pkg::MV_BITS-1:0] reg_target_mv,
	output logic [lpc_pkg::MV_BITS-1:0] pg_rise_mv,
	output logic [lpc_pkg::MV_BITS-1:0] pg_fall_mv,
	// Power-good open-drain pin: output value and enable
	output logic reg_power_good_out,
	output logic reg_power_good_oe,
	// Status
	output logic [1:0] enable_sel_q_out,
	output logic [1:0] power_mode_sel_out,
	output logic pin_wake_flag,
	output logic software_wake_flag,
	output logic seq_busy
);
	// ****************************************
	// Parameter checks
	// ****************************************
	initial
	begin
		if (DBNC_CYCLES < 1)
			$error("lpc_ctrl: DBNC_CYCLES must be at least 1");
		if (SEQ_CYCLES < 1)
			$error("lpc_ctrl: SEQ_CYCLES must be at least 1");
	end

	typedef enum logic [1:0] {ST_OFF, ST_RAMP_UP, ST_ON, ST_RAMP_DOWN} lpc_state_t;
	localparam int SW = $clog2(SEQ_CYCLES + 1);

	// ****************************************
	// Configuration registers
	// ****************************************
	logic [1:0] en_q;
	logic [1:0] en_d;
	logic [1:0] pm_q;
	logic [1:0] pm_d;
	logic [lpc_pkg::VOUT_BITS-1:0] vout_q;
	logic [lpc_pkg::VOUT_BITS-1:0] vout_d;
	logic pin_wake_q;
	logic pin_wake_d;
	logic sw_wake_q;
	logic sw_wake_d;
	logic sw_reset_pend_q;
	logic sw_reset_pend_d;
	logic sw_off_q;
	logic sw_off_d;
	logic pin_dbn;
	logic pin_dbn_prev_q;

	// Sequencer state, declared here because the wake flags read it
	lpc_state_t state_q;
	lpc_state_t state_d;
	logic [SW-1:0] seq_cnt_q;
	logic [SW-1:0] seq_cnt_d;
	logic reg_on_q;
	logic reg_on_d;
	logic seq_busy_q;
	wire state_is_off = state_q == ST_OFF;

	// Enable field reset value is a strap parameter, not a fixed constant
	assign en_d = reg_enable_sel_wr ? reg_enable_sel : en_q;
	assign pm_d = reg_power_mode_sel_wr ? reg_power_mode_sel : pm_q;
	assign vout_d = reg_vout_code_wr ? reg_vout_code : vout_q;

	lpc_debounce #(
		.CYCLES(DBNC_CYCLES)
	) u_pin_dbnc (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.din(~enable_pin_n),
		.dout(pin_dbn)
	);

	// ****************************************
	// Wake and shutdown sources
	// ****************************************
	wire hw_sw_mode = en_q == lpc_pkg::EN_HW_SW;
	wire pin_assert_evt = pin_dbn && !pin_dbn_prev_q;
	wire chg_valid = charger_input_detail == lpc_pkg::CHG_VALID;
	wire cmd_reset = software_power_cmd_wr && software_power_cmd == lpc_pkg::SW_RESET;
	wire cmd_off = software_power_cmd_wr && software_power_cmd != lpc_pkg::SW_NONE;
	wire lockout = sys_uvlo || sys_ovlo || over_temp;
	wire wdt_kill = watchdog_enabled && watchdog_expired_flag;
	wire kill = lockout || wdt_kill || manual_reset_flag || sw_off_q;
	wire sw_wake_set = sw_reset_pend_q && reset_actions_done && EN_DEFAULT == lpc_pkg::EN_HW_SW;

	// Wake flags: set wins over clear; the pin flag clears while off outside code 10, the software flag once ST_ON is reached
	assign pin_wake_d = (hw_sw_mode && pin_assert_evt) ? 1'b1 :
		(reg_on_q == 1'b0 && state_is_off && !hw_sw_mode) ? 1'b0 : pin_wake_q;
	assign sw_wake_d = sw_wake_set ? 1'b1 :
		(state_q == ST_ON) ? 1'b0 : sw_wake_q;
	assign sw_reset_pend_d = cmd_reset ? 1'b1 : (reset_actions_done ? 1'b0 : sw_reset_pend_q);
	// A software off command holds off until an enable field write or a software reset wake clears it
	assign sw_off_d = cmd_off ? 1'b1 :
		((reg_enable_sel_wr || sw_wake_set) ? 1'b0 : sw_off_q);

	wire want_on_hw = hw_sw_mode && (pin_wake_q || chg_valid || sw_wake_q);
	wire want_on_force = en_q == lpc_pkg::EN_FORCE_ON;
	// Force-off and the reserved code both leave want_on low
	wire want_on = (want_on_force || want_on_hw) && !kill;

	// ****************************************
	// On/off sequencer
	// ****************************************
	wire seq_done = seq_cnt_q == SW'(SEQ_CYCLES - 1);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_OFF:
				if (want_on)
					state_d = ST_RAMP_UP;
			ST_RAMP_UP:
				if (!want_on)
					state_d = ST_RAMP_DOWN;
				else if (seq_done)
					state_d = ST_ON;
			ST_ON:
				if (!want_on)
					state_d = ST_RAMP_DOWN;
			ST_RAMP_DOWN:
				if (seq_done)
					state_d = ST_OFF;
			default:
				state_d = ST_OFF;
		endcase
	end

	wire in_seq = state_q == ST_RAMP_UP || state_q == ST_RAMP_DOWN;
	assign seq_cnt_d = (state_d != state_q || !in_seq) ? '0 : seq_cnt_q + SW'(1);
	assign reg_on_d = state_d == ST_RAMP_UP || state_d == ST_ON;

	// ****************************************
	// Power mode and power-good
	// ****************************************
	logic normal_q;
	logic normal_d;
	// Kept inverted so the open-drain enable leaves a flip-flop directly
	logic pg_n_q;
	logic pg_d;
	// Pin modes assume the host keeps the pin driven; no chatter filter here
	wire pin_sense = pm_q[lpc_pkg::PM_PIN_BIT] ?
		(reg_mode_pin ^ (pm_q == lpc_pkg::PM_PIN_LOW)) : 1'b0;
	assign normal_d = pm_q[lpc_pkg::PM_PIN_BIT] ? pin_sense : (pm_q == lpc_pkg::PM_NORMAL);
	// Blank during sequences and while off; hysteresis between the two comparators
	assign pg_d = (state_q != ST_ON || state_d != ST_ON) ? 1'b0 :
		(vout_above_rise ? 1'b1 : (vout_below_fall ? 1'b0 : !pg_n_q));

	logic [lpc_pkg::MV_BITS-1:0] tgt_w;
	logic [lpc_pkg::MV_BITS-1:0] rise_w;
	logic [lpc_pkg::MV_BITS-1:0] fall_w;
	logic [lpc_pkg::MV_BITS-1:0] tgt_q;
	logic [lpc_pkg::MV_BITS-1:0] rise_q;
	logic [lpc_pkg::MV_BITS-1:0] fall_q;
	logic disch_q;

	lpc_vout_decode u_vdec (
		.code(vout_q),
		.target_mv(tgt_w),
		.rise_mv(rise_w),
		.fall_mv(fall_w)
	);

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			en_q <= EN_DEFAULT;
			pm_q <= lpc_pkg::PM_RESET_DEFAULT;
			vout_q <= lpc_pkg::VOUT_RESET_DEFAULT;
			pin_wake_q <= 1'b0;
			sw_wake_q <= 1'b0;
			sw_reset_pend_q <= 1'b0;
			sw_off_q <= 1'b0;
			pin_dbn_prev_q <= 1'b0;
			state_q <= ST_OFF;
			seq_cnt_q <= '0;
			reg_on_q <= 1'b0;
			normal_q <= 1'b0;
			pg_n_q <= 1'b1;
			seq_busy_q <= 1'b0;
			disch_q <= 1'b0;
			tgt_q <= '0;
			rise_q <= '0;
			fall_q <= '0;
		end
		else
		begin
			en_q <= en_d;
			pm_q <= pm_d;
			vout_q <= vout_d;
			pin_wake_q <= pin_wake_d;
			sw_wake_q <= sw_wake_d;
			sw_reset_pend_q <= sw_reset_pend_d;
			sw_off_q <= sw_off_d;
			pin_dbn_prev_q <= pin_dbn;
			state_q <= state_d;
			seq_cnt_q <= seq_cnt_d;
			reg_on_q <= reg_on_d;
			normal_q <= normal_d;
			pg_n_q <= !pg_d;
			seq_busy_q <= state_d == ST_RAMP_UP || state_d == ST_RAMP_DOWN;
			disch_q <= state_d == ST_OFF;
			tgt_q <= tgt_w;
			rise_q <= rise_w;
			fall_q <= fall_w;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_on = reg_on_q;
	assign reg_normal_mode = normal_q;
	assign reg_discharge_en = disch_q;
	assign reg_vout_code_out = vout_q;
	assign reg_target_mv = tgt_q;
	assign pg_rise_mv = rise_q;
	assign pg_fall_mv = fall_q;
	// Open drain: drive low whenever power is not good
	assign reg_power_good_out = 1'b0;
	assign reg_power_good_oe = pg_n_q;
	assign enable_sel_q_out = en_q;
	assign power_mode_sel_out = pm_q;
	assign pin_wake_flag = pin_wake_q;
	assign software_wake_flag = sw_wake_q;
	assign seq_busy = seq_busy_q;
endmodule

/* lpc_ctrl_checker.sv */
// Port-level checks for lpc_ctrl.
// Assumes it is bound to every lpc_ctrl instance.
`timescale 1ns/1ps
module lpc_ctrl_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Shutdown causes
	input wire logic sys_uvlo,
	input wire logic sys_ovlo,
	input wire logic over_temp,
	input wire logic watchdog_enabled,
	input wire logic watchdog_expired_flag,
	input wire logic manual_reset_flag,
	// Far side
	input wire logic reg_mode_pin,
	input wire logic vout_above_rise,
	// Outputs
	input wire logic reg_on,
	input wire logic reg_normal_mode,
	input wire logic reg_discharge_en,
	input wire logic [lpc_pkg::VOUT_BITS-1:0] reg_vout_code_out,
	input wire logic [lpc_pkg::MV_BITS-1:0] reg_target_mv,
	input wire logic reg_power_good_out,
	input wire logic reg_power_good_oe,
	input wire logic [1:0] enable_sel_q_out,
	input wire logic [1:0] power_mode_sel_out,
	input wire logic seq_busy
);
	// ****
	// Properties
	// ****
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire kill = sys_uvlo | sys_ovlo | over_temp | (watchdog_enabled & watchdog_expired_flag) | manual_reset_flag;

	a_force_on_up: assert property ($changed(enable_sel_q_out) && enable_sel_q_out == lpc_pkg::EN_FORCE_ON && !kill |=> reg_on)
		else $error("force on missed");
	a_force_off_down: assert property (enable_sel_q_out == lpc_pkg::EN_FORCE_OFF |=> !reg_on)
		else $error("force off missed");
	a_reserved_off: assert property (enable_sel_q_out == lpc_pkg::EN_RESERVED |=> !reg_on)
		else $error("reserved code on");
	a_kill_off: assert property (kill |=> !reg_on)
		else $error("shutdown ignored");
	a_mode_fixed: assert property (!power_mode_sel_out[1] |=> reg_normal_mode == $past(power_mode_sel_out[0]))
		else $error("fixed mode wrong");
	a_mode_pin_sense: assert property (power_mode_sel_out[1] |=> reg_normal_mode == ($past(reg_mode_pin) ^ $past(power_mode_sel_out[0])))
		else $error("pin mode wrong");
	a_vout_map: assert property (1'b1 |=> reg_target_mv == 12'(lpc_pkg::VOUT_BASE_MV + lpc_pkg::VOUT_STEP_MV * $past(reg_vout_code_out)))
		else $error("target mv wrong");
	a_pg_blank: assert property (seq_busy && $past(seq_busy) |-> reg_power_good_oe && !reg_power_good_out)
		else $error("power good not blanked");
	a_pg_release: assert property ((reg_on && !seq_busy && vout_above_rise && !kill)[*3] |-> !reg_power_good_oe)
		else $error("power good held low");
	a_discharge_off: assert property (reg_discharge_en |-> !reg_on && !seq_busy)
		else $error("discharge while on");

	c_on: cover property ($rose(reg_on));
	c_good: cover property ($fell(reg_power_good_oe));
	c_pin_mode: cover property (power_mode_sel_out == lpc_pkg::PM_PIN_LOW && reg_normal_mode);
endmodule

bind lpc_ctrl lpc_ctrl_checker i_chk (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.sys_uvlo(sys_uvlo),
	.sys_ovlo(sys_ovlo),
	.over_temp(over_temp),
	.watchdog_enabled(watchdog_enabled),
	.watchdog_expired_flag(watchdog_expired_flag),
	.manual_reset_flag(manual_reset_flag),
	.reg_mode_pin(reg_mode_pin),
	.vout_above_rise(vout_above_rise),
	.reg_on(reg_on),
	.reg_normal_mode(reg_normal_mode),
	.reg_discharge_en(reg_discharge_en),
	.reg_vout_code_out(reg_vout_code_out),
	.reg_target_mv(reg_target_mv),
	.reg_power_good_out(reg_power_good_out),
	.reg_power_good_oe(reg_power_good_oe),
	.enable_sel_q_out(enable_sel_q_out),
	.power_mode_sel_out(power_mode_sel_out),
	.seq_busy(seq_busy)
);

/* lpc_host_model.sv */
// Far-side model: mode pin driver and output voltage comparators.
// Assumes the output ramps up while reg_on is high and decays otherwise.
`timescale 1ns/1ps
module lpc_host_model (
	// Clock and controls
	input wire logic sys_clk,
	input wire logic reg_on,
	input wire logic [1:0] power_mode_sel_out,
	input wire logic mode_req,
	input wire logic fast,
	// Towards the block
	output logic reg_mode_pin,
	output logic vout_above_rise,
	output logic vout_below_fall
);
	logic [4:0] lvl_q = 5'h00;
	logic tgl_q = 1'b0;
	// Pin is a don't care with the mode MSB clear, so it chatters there
	assign reg_mode_pin = power_mode_sel_out[1] ? mode_req : tgl_q;
	assign vout_above_rise = lvl_q >= 5'h1c;
	assign vout_below_fall = lvl_q < 5'h1b;
	always @(posedge sys_clk)
	begin
		tgl_q <= !tgl_q;
		if (reg_on && lvl_q < 5'h1c)
			lvl_q <= lvl_q + (fast ? 5'h04 : 5'h01);
		else if (!reg_on && lvl_q != 5'h00)
			lvl_q <= lvl_q - 5'h01;
	end
endmodule

/* lpc_ctrl_bench.sv */
// Self-checking bench for lpc_ctrl with the host model on the far side.
// Assumes short debounce and sequence counts at the instance.
`timescale 1ns/1ps
module lpc_ctrl_bench;
	localparam int SEQ = 8;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [6:0] dat = 7'h00;
	logic [3:0] wr_v = 4'h0;
	logic [4:0] kill = 5'h00;
	logic [1:0] chg = 2'h0;
	logic pin_n = 1'b1, mode_req = 1'b0, fast = 1'b1, done = 1'b0, wd_en = 1'b1;
	logic reg_on, normal, disch, oe, pgo, pwake, swake, above, below, mpin;
	logic [1:0] en_q, pm_q;
	logic [11:0] tmv, rmv, fmv;
	int bad_count = 0, n_compared = 0, cyc = 0, rnd;
	always #2 sys_clk = !sys_clk;

	lpc_ctrl #(.DBNC_CYCLES(4), .SEQ_CYCLES(SEQ)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
		.reg_enable_sel(dat[1:0]), .reg_enable_sel_wr(wr_v[0]), .reg_vout_code(dat), .reg_vout_code_wr(wr_v[1]),
		.reg_power_mode_sel(dat[1:0]), .reg_power_mode_sel_wr(wr_v[2]),
		.software_power_cmd(dat[1:0]), .software_power_cmd_wr(wr_v[3]),
		.enable_pin_n(pin_n), .charger_input_detail(chg), .reg_mode_pin(mpin),
		.sys_uvlo(kill[0]), .sys_ovlo(kill[1]), .over_temp(kill[2]), .watchdog_enabled(wd_en),
		.watchdog_expired_flag(kill[3]), .manual_reset_flag(kill[4]), .reset_actions_done(done),
		.vout_above_rise(above), .vout_below_fall(below), .reg_on(reg_on), .reg_normal_mode(normal),
		.reg_discharge_en(disch), .reg_vout_code_out(), .reg_target_mv(tmv), .pg_rise_mv(rmv), .pg_fall_mv(fmv),
		.reg_power_good_out(pgo), .reg_power_good_oe(oe), .enable_sel_q_out(en_q), .power_mode_sel_out(pm_q),
		.pin_wake_flag(pwake), .software_wake_flag(swake), .seq_busy());
	lpc_host_model i_host (.sys_clk(sys_clk), .reg_on(reg_on), .power_mode_sel_out(pm_q), .mode_req(mode_req),
		.fast(fast), .reg_mode_pin(mpin), .vout_above_rise(above), .vout_below_fall(below));

	// ****
	// Helpers
	// ****
	task automatic wait_n(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// One-cycle write strobe; data bus is shared by all fields
	task automatic wr(input int f, input logic [6:0] v);
		@(negedge sys_clk);
		dat = v;
		wr_v = 4'(1 << f);
		@(negedge sys_clk);
		wr_v = 4'h0;
	endtask
	task automatic chk_mv(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_mv({11'h000, got}, {11'h000, exp});
	endtask
	function automatic logic [11:0] exp_mv(input logic [6:0] c);
		return 12'(lpc_pkg::VOUT_BASE_MV + lpc_pkg::VOUT_STEP_MV * c);
	endfunction
	// Thresholds: 87.5% as 7/8 and 84% as 21/25, truncated
	function automatic logic [11:0] exp_rise(input logic [6:0] c);
		return 12'(int'(exp_mv(c)) * 7 / 8);
	endfunction
	function automatic logic [11:0] exp_fall(input logic [6:0] c);
		return 12'(int'(exp_mv(c)) * 21 / 25);
	endfunction
	function automatic logic exp_norm(input logic [1:0] pm, input logic pin);
		return pm[1] ? (pin ^ pm[0]) : pm[0];
	endfunction
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			bad_count++;
			give_verdict();
		end
	end

	// ****
	// Tests
	// ****
	initial
	begin
		rnd = $urandom(58010);
		wait_n(4);
		rstn = 1'b1;
		wait_n(2);
		chk_bit(en_q === lpc_pkg::EN_RESET_DEFAULT, 1'b1);
		chk_bit(reg_on, 1'b0);
		wr(3, 7'(lpc_pkg::SW_RESET));
		wait_n(3);
		chk_bit(reg_on, 1'b0);
		done = 1'b1;
		wait_n(1);
		done = 1'b0;
		wait_n(4);
		chk_bit(reg_on, 1'b1);
		chk_bit(swake, 1'b1);
		// Let the ramp reach on so the software wake flag is spent
		wait_n(SEQ);
		chk_bit(swake, 1'b0);
		wr(3, 7'(lpc_pkg::SW_POWER_OFF));
		wait_n(3);
		chk_bit(reg_on, 1'b0);
		wr(0, 7'(lpc_pkg::EN_HW_SW));
		repeat (6)
		begin
			chg = 2'($urandom_range(2));
			wait_n(3);
			chk_bit(reg_on, 1'b0);
		end
		chg = lpc_pkg::CHG_VALID;
		wait_n(3);
		chk_bit(reg_on, 1'b1);
		chg = 2'h0;
		wr(3, 7'(lpc_pkg::SW_SHIP));
		wait_n(3);
		chk_bit(reg_on, 1'b0);
		$display("wake sources done");
		wr(0, 7'(lpc_pkg::EN_HW_SW));
		pin_n = 1'b0;
		wait_n(2);
		chk_bit(pwake, 1'b0);
		wait_n(8);
		chk_bit(pwake, 1'b1);
		chk_bit(reg_on, 1'b1);
		// Last pass: watchdog expiry with the watchdog disabled must not cut power
		for (int i = 0; i < 6; i++)
		begin
			wd_en = (i != 5);
			kill = (i == 5) ? 5'h08 : 5'h01 << i;
			wait_n(3);
			chk_bit(reg_on, i == 5);
			kill = 5'h00;
			// Power-down sequence must finish before power-up restarts
			wait_n(SEQ + 4);
			chk_bit(reg_on, 1'b1);
		end
		$display("shutdown causes done");
		pin_n = 1'b1;
		wr(0, 7'(lpc_pkg::EN_RESERVED));
		wait_n(3);
		chk_bit(reg_on, 1'b0);
		wait_n(SEQ);
		fast = 1'b0;
		wr(0, 7'(lpc_pkg::EN_FORCE_ON));
		wait_n(2);
		chk_bit(reg_on, 1'b1);
		chk_bit(oe, 1'b1);
		wait_n(SEQ + 32);
		chk_bit(oe, 1'b0);
		chk_bit(pgo, 1'b0);
		wr(0, 7'(lpc_pkg::EN_FORCE_OFF));
		wait_n(2);
		chk_bit(reg_on, 1'b0);
		wait_n(SEQ + 4);
		chk_bit(oe, 1'b1);
		chk_bit(disch, 1'b1);
		$display("enable codes done");
		for (int i = 0; i < 8; i++)
		begin
			mode_req = i[0];
			wr(2, 7'(i >> 1));
			wait_n(3);
			chk_bit(normal, exp_norm(2'(i >> 1), i[0]));
		end
		for (int i = 0; i < 10; i++)
		begin
			rnd = (i == 0) ? 0 : (i == 1) ? 127 : $urandom_range(127);
			wr(1, 7'(rnd));
			wait_n(3);
			chk_mv(tmv, exp_mv(7'(rnd)));
			chk_mv(rmv, exp_rise(7'(rnd)));
			chk_mv(fmv, exp_fall(7'(rnd)));
		end
		$display("mode and voltage done");
		give_verdict();
	end
endmodule
